// ---- dv/fbm_board_model.sv ----
module fbm_board_model (
    input wire logic clk_sys,
    output logic rst_b,
    output logic mode_select_pin_one,
    output logic mode_select_pin_zero,
    output logic boot_select_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    import fbm_pkg::*;
    // ==========================================================
    // Board reset driver and mode straps
    initial begin
        rst_b = 1'h0;
        mode_select_pin_one = 1'h1;
        mode_select_pin_zero = 1'h1;
        boot_select_pin = 1'h0;
    end
    // Straps move only after reset is low, never while running
    task automatic strap_reset(input logic [2:0] code, input int hold);
        int n;
        n = (hold < RST_MIN_CYC) ? RST_MIN_CYC : hold;
        @(posedge clk_sys);
        rst_b <= 1'h0;
        @(posedge clk_sys);
        {mode_select_pin_one, mode_select_pin_zero, boot_select_pin} <= code;
        repeat (n) @(posedge clk_sys);
    endtask : strap_reset
    task automatic release_reset();
        @(posedge clk_sys);
        rst_b <= 1'h1;
    endtask : release_reset
endmodule : fbm_board_model

// ---- dv/tb_top.sv ----
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import fbm_pkg::*;
    // ==========================================================
    // Signals
    logic clk_sys, rst_b, pin_one, pin_zero, pin_boot;
    fbm_cmd_t cmd_s;
    logic rd_req;
    logic [ADDR_W-1:0] rd_addr;
    fbm_mode_t mode;
    logic cpu_run, fetch_boot_rom, fetch_flash, programmer_mode;
    logic boot_pin_level, cmd_ready, op_done, cmd_err, rd_valid;
    logic [WORD_W-1:0] rd_data;
    logic rd_refused, read_protected, dn, er;
    int fail_count, cmp_count, cyc, c, i;
    int seed = 32'hff36;
    logic [2:0] code;
    logic [15:0] addr_q [6];
    logic [15:0] data_q [6];
    // ==========================================================
    // Instances
    fbm_board_model fbm_board_model_inst (
        .clk_sys(clk_sys), .rst_b(rst_b), .mode_select_pin_one(pin_one),
        .mode_select_pin_zero(pin_zero), .boot_select_pin(pin_boot));
    fbm_mode_ctrl fbm_mode_ctrl_inst (
        .clk_sys(clk_sys), .rst_b(rst_b), .mode_select_pin_zero(pin_zero),
        .mode_select_pin_one(pin_one), .boot_select_pin(pin_boot),
        .cmd(cmd_s), .rd_req(rd_req), .rd_addr(rd_addr), .mode(mode),
        .cpu_run(cpu_run), .fetch_boot_rom(fetch_boot_rom),
        .fetch_flash(fetch_flash), .programmer_mode(programmer_mode),
        .boot_pin_level(boot_pin_level), .cmd_ready(cmd_ready),
        .op_done(op_done), .cmd_err(cmd_err), .rd_valid(rd_valid),
        .rd_data(rd_data), .rd_refused(rd_refused),
        .read_protected(read_protected));
    initial begin
        clk_sys = 1'h0;
        forever #10 clk_sys = ~clk_sys;
    end
    // ==========================================================
    // Helpers
    function automatic fbm_mode_t exp_mode(input logic [1:0] pins);
        if (pins == AM_SINGLE_CHIP) return MODE_SINGLE_CHIP;
        if (pins == AM_SERIAL_BOOT) return MODE_SERIAL_BOOT;
        return MODE_RESERVED;
    endfunction : exp_mode
    task automatic summarize();
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : summarize
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic launch(input fbm_op_t op, input logic [15:0] a,
                          input logic [15:0] d);
        @(posedge clk_sys);
        cmd_s <= '{1'h1, op, a, d};
        @(posedge clk_sys);
        cmd_s.valid <= 1'h0;
    endtask : launch
    // Bounded wait; pulses last one cycle so every cycle is sampled
    task automatic wait_resp(output logic d, output logic e);
        int n;
        d = 1'h0;
        e = 1'h0;
        for (n = 0; n < 60000 && !(d || e); n++) begin
            #1;
            d = (op_done === 1'h1);
            e = (cmd_err === 1'h1);
            if (!(d || e)) @(posedge clk_sys);
        end
    endtask : wait_resp
    task automatic issue(input fbm_op_t op, input logic [15:0] a,
                         input logic [15:0] d, input logic bad);
        logic d1;
        logic e1;
        launch(op, a, d);
        wait_resp(d1, e1);
        check(e1, bad);
        check(d1, !bad);
    endtask : issue
    task automatic rd_check(input logic [15:0] a, input logic [15:0] d,
                            input logic refused);
        @(posedge clk_sys);
        rd_req <= 1'h1;
        rd_addr <= a;
        @(posedge clk_sys);
        rd_req <= 1'h0;
        #1;
        check(rd_valid, 1'h1);
        check(rd_data, d);
        check(rd_refused, refused);
    endtask : rd_check
    // Ceiling well above one chip erase plus one sector erase
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 80000) begin
            fail_count++;
            summarize();
        end
    end
    // ==========================================================
    // Tests
    initial begin
        cmd_s = '0;
        rd_req = 1'h0;
        rd_addr = '0;
        fbm_board_model_inst.strap_reset(3'h7, 12);
        for (c = 0; c < 4; c++) begin
            code = {c[1:0], 1'($random(seed))};
            fbm_board_model_inst.strap_reset(code, 10 + ($random(seed) & 3));
            #1;
            check(mode, MODE_RESERVED);
            check(cpu_run, 1'h0);
            check(programmer_mode, c == 2);
            check(boot_pin_level, code[0]);
            if (c != 2) begin
                fbm_board_model_inst.release_reset();
                repeat (2) @(posedge clk_sys);
                #1;
                check(mode, exp_mode(c[1:0]));
                check(cpu_run, c[0]);
                check(fetch_flash, c == 3);
                check(fetch_boot_rom, c == 1);
                if (c == 0) issue(OP_PROGRAM, '0, 16'h1234, 1'h1);
            end
        end
        $display("test decode done");
        issue(OP_CHIP_ERASE, '0, '0, 1'h0);
        check(read_protected, 1'h0);
        for (i = 0; i < 6; i++) begin
            addr_q[i] = {4'(i * 2), 12'($random(seed))};
            data_q[i] = 16'($random(seed));
            rd_check(addr_q[i], ERASED_WORD, 1'h0);
            issue(OP_PROGRAM, addr_q[i], data_q[i], 1'h0);
            rd_check(addr_q[i], data_q[i], 1'h0);
        end
        issue(OP_PROGRAM, 16'hbfff, data_q[5], 1'h0);
        rd_check(16'hbfff, data_q[5], 1'h0);
        issue(OP_PROGRAM, 16'hc000, 16'h0, 1'h1);
        rd_check(16'hc000, REFUSED_WORD, 1'h1);
        issue(OP_READ_PROTECT, '0, '0, 1'h1);
        launch(OP_SECTOR_ERASE, addr_q[1], '0);
        @(posedge clk_sys);
        #1;
        check(cmd_ready, 1'h0);
        issue(OP_PROGRAM, addr_q[0], 16'h0, 1'h1);
        // Let the refusal pulse pass before waiting for done
        @(posedge clk_sys);
        wait_resp(dn, er);
        check(dn, 1'h1);
        check(er, 1'h0);
        rd_check(addr_q[1], ERASED_WORD, 1'h0);
        rd_check({addr_q[1][15:12], 12'h000}, ERASED_WORD, 1'h0);
        rd_check(addr_q[0], data_q[0], 1'h0);
        rd_check(addr_q[2], data_q[2], 1'h0);
        $display("test flash done");
        fbm_board_model_inst.strap_reset(3'h2, 10);
        fbm_board_model_inst.release_reset();
        repeat (3) @(posedge clk_sys);
        issue(OP_PROGRAM, addr_q[1], data_q[1], 1'h0);
        rd_check(addr_q[1], data_q[1], 1'h0);
        $display("test boot done");
        fbm_board_model_inst.strap_reset(3'h4, 10);
        #1;
        check(cpu_run, 1'h0);
        check(programmer_mode, 1'h1);
        issue(OP_PROGRAM, addr_q[3] + 16'h1, data_q[3], 1'h0);
        rd_check(addr_q[3] + 16'h1, data_q[3], 1'h0);
        issue(OP_READ_PROTECT, '0, '0, 1'h0);
        @(posedge clk_sys);
        #1;
        check(read_protected, 1'h1);
        rd_check(addr_q[3], REFUSED_WORD, 1'h1);
        $display("test programmer done");
        summarize();
    end
endmodule : tb_top

// ---- src/fbm_flash_seq.sv ----
module fbm_flash_seq #(
    parameter int WORDS = fbm_pkg::FLASH_WORDS,
    parameter int SECT = fbm_pkg::SECT_WORDS
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire fbm_pkg::fbm_cmd_t cmd,
    input wire logic allow,
    input wire logic prog_mode,
    input wire logic rd_req,
    input wire logic [fbm_pkg::ADDR_W-1:0] rd_addr,
    output logic ready,
    output logic op_done,
    output logic cmd_err,
    output logic rd_valid,
    output logic [fbm_pkg::WORD_W-1:0] rd_data,
    output logic rd_refused,
    output logic protected_flag
);
    import fbm_pkg::*;

    localparam logic [ADDR_W-1:0] LAST = ADDR_W'(WORDS - 1);
    localparam logic [ADDR_W-1:0] SMASK = ADDR_W'(SECT - 1);

    typedef enum logic {ST_IDLE, ST_ERASE} fbm_seq_st_t;

    // Nonvolatile cells: no reset, contents survive every reset
    logic [WORD_W-1:0] mem [WORDS];
    logic prot_cell;

    fbm_seq_st_t st_r, st_nxt;
    logic [ADDR_W-1:0] ptr_r, ptr_nxt, end_r, end_nxt;
    logic ready_r, ready_nxt, done_r, done_nxt, err_r, err_nxt;
    logic rdv_r, rdv_nxt, rdr_r, rdr_nxt, prot_r, prot_nxt;
    logic [WORD_W-1:0] rdd_r, rdd_nxt;
    logic we, prot_we, prot_wd, blk;
    logic [ADDR_W-1:0] wa;
    logic [WORD_W-1:0] wd;

    // ==========================================================
    // Command sequencer
    always_comb begin
        st_nxt = st_r;
        ptr_nxt = ptr_r;
        end_nxt = end_r;
        done_nxt = 1'b0;
        err_nxt = 1'b0;
        we = 1'b0;
        wa = ptr_r;
        wd = ERASED_WORD;
        prot_we = 1'b0;
        prot_wd = 1'b0;
        case (st_r)
            ST_IDLE: begin
                if (cmd.valid && !allow) begin
                    err_nxt = 1'b1;
                end else if (cmd.valid) begin
                    case (cmd.op)
                        OP_PROGRAM: begin
                            if (cmd.addr > LAST) begin
                                err_nxt = 1'b1;
                            end else begin
                                we = 1'b1;
                                wa = cmd.addr;
                                wd = cmd.data;
                                done_nxt = 1'b1;
                            end
                        end
                        OP_CHIP_ERASE: begin
                            ptr_nxt = '0;
                            end_nxt = LAST;
                            st_nxt = ST_ERASE;
                            // Wiping all data also lifts the protection
                            prot_we = 1'b1;
                        end
                        OP_SECTOR_ERASE: begin
                            if (cmd.addr > LAST) begin
                                err_nxt = 1'b1;
                            end else begin
                                ptr_nxt = cmd.addr & ~SMASK;
                                end_nxt = cmd.addr | SMASK;
                                st_nxt = ST_ERASE;
                            end
                        end
                        OP_READ_PROTECT: begin
                            prot_we = prog_mode;
                            prot_wd = 1'b1;
                            done_nxt = prog_mode;
                            err_nxt = !prog_mode;
                        end
                        default: err_nxt = 1'b1;
                    endcase
                end
            end
            ST_ERASE: begin
                // One word per cycle, no software help needed
                we = 1'b1;
                ptr_nxt = ptr_r + 1'b1;
                err_nxt = cmd.valid;
                if (ptr_r == end_r) begin
                    st_nxt = ST_IDLE;
                    done_nxt = 1'b1;
                end
            end
            default: st_nxt = ST_IDLE;
        endcase
        ready_nxt = (st_nxt == ST_IDLE);
    end

    // ==========================================================
    // Read port
    always_comb begin
        blk = prot_cell && prog_mode;
        rdv_nxt = rd_req;
        rdr_nxt = rd_req && (blk || rd_addr > LAST);
        rdd_nxt = REFUSED_WORD;
        if (rd_req && !rdr_nxt) begin
            rdd_nxt = mem[rd_addr];
        end
        prot_nxt = prot_cell;
    end

    always_ff @(posedge clk_sys) begin
        if (we) begin
            mem[wa] <= wd;
        end
        if (prot_we) begin
            prot_cell <= prot_wd;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            st_r <= ST_IDLE;
            ptr_r <= '0;
            end_r <= '0;
            ready_r <= 1'b0;
            done_r <= 1'b0;
            err_r <= 1'b0;
            rdv_r <= 1'b0;
            rdr_r <= 1'b0;
            rdd_r <= '0;
            prot_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            ptr_r <= ptr_nxt;
            end_r <= end_nxt;
            ready_r <= ready_nxt;
            done_r <= done_nxt;
            err_r <= err_nxt;
            rdv_r <= rdv_nxt;
            rdr_r <= rdr_nxt;
            rdd_r <= rdd_nxt;
            prot_r <= prot_nxt;
        end
    end

    assign ready = ready_r;
    assign op_done = done_r;
    assign cmd_err = err_r;
    assign rd_valid = rdv_r;
    assign rd_data = rdd_r;
    assign rd_refused = rdr_r;
    assign protected_flag = prot_r;

    // ==========================================================
    // Checks
    property p_prog_word;
        @(posedge clk_sys) disable iff (!rst_b)
        (st_r == ST_IDLE && cmd.valid && allow && cmd.op == OP_PROGRAM
            && cmd.addr <= LAST)
        |=> done_r && ready_r && mem[$past(cmd.addr)] == $past(cmd.data);
    endproperty
    a_prog_word: assert property (p_prog_word)
        else $error("program word not written");

    property p_sect_span;
        @(posedge clk_sys) disable iff (!rst_b)
        (st_r == ST_IDLE && cmd.valid && allow && cmd.op == OP_SECTOR_ERASE
            && cmd.addr <= LAST)
        |=> st_r == ST_ERASE && (end_r - ptr_r) == SMASK
            && (ptr_r & SMASK) == '0;
    endproperty
    a_sect_span: assert property (p_sect_span)
        else $error("sector erase span wrong");

    property p_erase_end;
        @(posedge clk_sys) disable iff (!rst_b)
        (st_r == ST_ERASE && ptr_r == end_r) |=> done_r && ready_r
            && mem[$past(ptr_r)] == ERASED_WORD;
    endproperty
    a_erase_end: assert property (p_erase_end)
        else $error("erase did not finish cleanly");

    property p_rd_block;
        @(posedge clk_sys) disable iff (!rst_b)
        (rd_req && prot_cell && prog_mode)
        |=> rd_valid && rd_refused && rd_data == REFUSED_WORD;
    endproperty
    a_rd_block: assert property (p_rd_block)
        else $error("protected read not refused");

    property p_no_allow;
        @(posedge clk_sys) disable iff (!rst_b)
        (st_r == ST_IDLE && cmd.valid && !allow) |=> cmd_err && !op_done;
    endproperty
    a_no_allow: assert property (p_no_allow)
        else $error("command taken outside a programming mode");
endmodule : fbm_flash_seq

// ---- src/fbm_mode_ctrl.sv ----
module fbm_mode_ctrl (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic mode_select_pin_zero,
    input wire logic mode_select_pin_one,
    input wire logic boot_select_pin,
    input wire fbm_pkg::fbm_cmd_t cmd,
    input wire logic rd_req,
    input wire logic [fbm_pkg::ADDR_W-1:0] rd_addr,
    output fbm_pkg::fbm_mode_t mode,
    output logic cpu_run,
    output logic fetch_boot_rom,
    output logic fetch_flash,
    output logic programmer_mode,
    output logic boot_pin_level,
    output logic cmd_ready,
    output logic op_done,
    output logic cmd_err,
    output logic rd_valid,
    output logic [fbm_pkg::WORD_W-1:0] rd_data,
    output logic rd_refused,
    output logic read_protected
);
    import fbm_pkg::*;

    function automatic fbm_mode_t mode_of(input logic one, input logic zero);
        case ({one, zero})
            AM_SINGLE_CHIP: mode_of = MODE_SINGLE_CHIP;
            AM_SERIAL_BOOT: mode_of = MODE_SERIAL_BOOT;
            AM_PROGRAMMER: mode_of = MODE_PROGRAMMER;
            default: mode_of = MODE_RESERVED;
        endcase
    endfunction

    // ==========================================================
    // Strap capture, live only while reset is low
    // Needs the clock running under reset, which the ten-clock
    // reset guarantees; no async reset so pin levels may enter
    fbm_strap_t strap_r, strap_nxt;
    logic prog_r, prog_nxt, seq_rst_b_r, seq_rst_b_nxt;
    fbm_mode_t live_mode;

    always_comb begin
        live_mode = mode_of(mode_select_pin_one, mode_select_pin_zero);
        strap_nxt = strap_r;
        if (!rst_b) begin
            strap_nxt = '{one: mode_select_pin_one,
                          zero: mode_select_pin_zero,
                          boot: boot_select_pin};
        end
        prog_nxt = !rst_b && live_mode == MODE_PROGRAMMER;
        // Sequencer stays alive under reset in programmer mode
        seq_rst_b_nxt = rst_b || prog_nxt;
    end

    always_ff @(posedge clk_sys) begin
        strap_r <= strap_nxt;
        prog_r <= prog_nxt;
        seq_rst_b_r <= seq_rst_b_nxt;
    end

    // ==========================================================
    // Start-up after release
    fbm_mode_t mode_r, mode_nxt;
    logic run_r, run_nxt, rom_r, rom_nxt, fl_r, fl_nxt;

    always_comb begin
        mode_nxt = mode_r;
        run_nxt = run_r;
        rom_nxt = rom_r;
        fl_nxt = fl_r;
        // Straps are ignored once running
        if (!run_r) begin
            mode_nxt = mode_of(strap_r.one, strap_r.zero);
            run_nxt = mode_nxt == MODE_SINGLE_CHIP
                || mode_nxt == MODE_SERIAL_BOOT;
            rom_nxt = mode_nxt == MODE_SERIAL_BOOT;
            // No normal/user-boot split: software picks that
            fl_nxt = mode_nxt == MODE_SINGLE_CHIP;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            mode_r <= MODE_RESERVED;
            run_r <= 1'b0;
            rom_r <= 1'b0;
            fl_r <= 1'b0;
        end else begin
            mode_r <= mode_nxt;
            run_r <= run_nxt;
            rom_r <= rom_nxt;
            fl_r <= fl_nxt;
        end
    end

    // ==========================================================
    // Flash command engine
    fbm_flash_seq #(
        .WORDS(FLASH_WORDS),
        .SECT(SECT_WORDS)
    ) u_seq (
        .clk_sys(clk_sys),
        .rst_b(seq_rst_b_r),
        .cmd(cmd),
        .allow(prog_r || run_r),
        .prog_mode(prog_r),
        .rd_req(rd_req),
        .rd_addr(rd_addr),
        .ready(cmd_ready),
        .op_done(op_done),
        .cmd_err(cmd_err),
        .rd_valid(rd_valid),
        .rd_data(rd_data),
        .rd_refused(rd_refused),
        .protected_flag(read_protected)
    );

    assign mode = mode_r;
    assign cpu_run = run_r;
    assign fetch_boot_rom = rom_r;
    assign fetch_flash = fl_r;
    assign programmer_mode = prog_r;
    assign boot_pin_level = strap_r.boot;

    // ==========================================================
    // Checks
    sequence s_release;
        !$past(rst_b) ##0 rst_b;
    endsequence

    property p_single;
        @(posedge clk_sys) disable iff (!rst_b)
        (s_release ##0 (strap_r.one && strap_r.zero))
        |=> cpu_run && fetch_flash && !fetch_boot_rom
            && mode == MODE_SINGLE_CHIP;
    endproperty
    a_single: assert property (p_single)
        else $error("single chip start wrong");

    property p_serial;
        @(posedge clk_sys) disable iff (!rst_b)
        (s_release ##0 (!strap_r.one && strap_r.zero))
        |=> cpu_run && fetch_boot_rom && !fetch_flash
            && mode == MODE_SERIAL_BOOT;
    endproperty
    a_serial: assert property (p_serial)
        else $error("serial boot start wrong");

    property p_reserved;
        @(posedge clk_sys) disable iff (!rst_b)
        (s_release ##0 !strap_r.zero) |=> !cpu_run [*4];
    endproperty
    a_reserved: assert property (p_reserved)
        else $error("cpu ran on undefined strap");

    property p_prog_held;
        @(posedge clk_sys)
        programmer_mode |-> !cpu_run && !fetch_flash && !fetch_boot_rom;
    endproperty
    a_prog_held: assert property (p_prog_held)
        else $error("cpu active in programmer mode");

    property p_hold_mode;
        @(posedge clk_sys) disable iff (!rst_b)
        cpu_run |=> cpu_run && $stable(mode) && $stable(fetch_flash);
    endproperty
    a_hold_mode: assert property (p_hold_mode)
        else $error("running mode changed");

    // ==========================================================
    // Reset-side checks
    sequence s_held;
        !rst_b ##1 !rst_b;
    endsequence

    property p_held_quiet;
        @(posedge clk_sys)
        s_held |-> !cpu_run && !fetch_flash && !fetch_boot_rom
            && mode == MODE_RESERVED;
    endproperty
    a_held_quiet: assert property (p_held_quiet)
        else $error("cpu active while reset held");

    property p_boot_level;
        @(posedge clk_sys)
        !rst_b |=> boot_pin_level == $past(boot_select_pin);
    endproperty
    a_boot_level: assert property (p_boot_level)
        else $error("boot strap not captured in reset");

    property p_strap_kept;
        @(posedge clk_sys)
        rst_b |=> $stable(boot_pin_level);
    endproperty
    a_strap_kept: assert property (p_strap_kept)
        else $error("strap copy moved while running");

    property p_prog_entry;
        @(posedge clk_sys)
        (!rst_b && mode_select_pin_one && !mode_select_pin_zero)
        |=> programmer_mode;
    endproperty
    a_prog_entry: assert property (p_prog_entry)
        else $error("programmer straps not taken");

    property p_prog_exit;
        @(posedge clk_sys)
        rst_b |=> !programmer_mode;
    endproperty
    a_prog_exit: assert property (p_prog_exit)
        else $error("programmer mode kept after release");

    property p_fetch_one;
        @(posedge clk_sys) disable iff (!rst_b)
        (fetch_flash || fetch_boot_rom) |-> cpu_run
            && !(fetch_flash && fetch_boot_rom);
    endproperty
    a_fetch_one: assert property (p_fetch_one)
        else $error("fetch source not unique");
endmodule : fbm_mode_ctrl

// ---- src/fbm_pkg.sv ----
package fbm_pkg;
    // ==========================================================
    // Flash organisation
    localparam int WORD_W = 16;
    localparam int ADDR_W = 16;
    localparam int FLASH_WORDS = 49152;
    localparam int SECT_WORDS = 4096;
    localparam int SECT_COUNT = 12;
    localparam logic [WORD_W-1:0] ERASED_WORD = 16'hffff;
    localparam logic [WORD_W-1:0] REFUSED_WORD = 16'h0000;
    // ==========================================================
    // Strap codes, {mode_select_pin_one, mode_select_pin_zero}
    localparam logic [1:0] AM_SINGLE_CHIP = 2'h3;
    localparam logic [1:0] AM_SERIAL_BOOT = 2'h1;
    localparam logic [1:0] AM_PROGRAMMER = 2'h2;
    // ==========================================================
    // Reset timing
    localparam int RST_MIN_CYC = 10;
    // ==========================================================
    // Types
    typedef enum logic [1:0] {
        MODE_RESERVED,
        MODE_SINGLE_CHIP,
        MODE_SERIAL_BOOT,
        MODE_PROGRAMMER
    } fbm_mode_t;
    typedef enum logic [1:0] {
        OP_PROGRAM,
        OP_CHIP_ERASE,
        OP_SECTOR_ERASE,
        OP_READ_PROTECT
    } fbm_op_t;
    typedef struct packed {
        logic valid;
        fbm_op_t op;
        logic [ADDR_W-1:0] addr;
        logic [WORD_W-1:0] data;
    } fbm_cmd_t;
    typedef struct packed {
        logic one;
        logic zero;
        logic boot;
    } fbm_strap_t;
endpackage : fbm_pkg
